// file: inc/lpl_consts.svh
`ifndef LPL_CONSTS_SVH
`define LPL_CONSTS_SVH
// register offsets (byte addresses on the plain port)
`define LPL_ADDR_CTRL 8'h00
`define LPL_ADDR_STATUS 8'h04
`define LPL_ADDR_IRQ_STAT 8'h08
`define LPL_ADDR_IRQ_MASK 8'h0c
`define LPL_ADDR_OCP_LVL 8'h10
`define LPL_ADDR_OCP_DLY 8'h14
`define LPL_ADDR_OPP_LVL 8'h18
`define LPL_ADDR_OPP_DLY 8'h1c
`define LPL_ADDR_VON 8'h20
`define LPL_ADDR_VMARK1 8'h24
`define LPL_ADDR_VMARK2 8'h28
`define LPL_ADDR_TIMER 8'h2c
`define LPL_ADDR_CLEAR 8'h30
`define LPL_ADDR_SLOT 8'h34
`define LPL_ADDR_SET_MODE 8'h38
`define LPL_ADDR_SET_VOLT 8'h3c
`define LPL_ADDR_SET_CURR 8'h40
`define LPL_ADDR_KNEE 8'h44
// ctrl bit positions
`define LPL_CTRL_INPUT_ON 0
`define LPL_CTRL_OCP_EN 1
`define LPL_CTRL_VON_LATCH 2
`define LPL_CTRL_TIMER_EN 3
`define LPL_CTRL_CV_MODE 4
`define LPL_CTRL_DIODE 5
// status bit positions
`define LPL_ST_OV 0
`define LPL_ST_VF 1
`define LPL_ST_OC 2
`define LPL_ST_OP 3
`define LPL_ST_OT 4
`define LPL_ST_PS 5
`define LPL_ST_LOADING 6
`define LPL_ST_INPUT 7
`define LPL_ST_TMR_BUSY 8
`define LPL_ST_FALLING 9
// irq bits: 0 ov, 1 ocp soft, 2 opp soft, 3 otp, 4 timer done
`define LPL_IRQ_W 5
// reset values and limits
`define LPL_CTRL_RST 16'h0000
`define LPL_VON_MIN 16'h0001
`define LPL_OCP_LVL_RST 16'hffff
`define LPL_SLOTS 100
`define LPL_SLOT_MAX 7'h63
// heat trip, in tenths of a degree: 85.0 C
`define LPL_HEAT_TRIP 16'h0352
// current guard limit is 110 percent of range
`define LPL_HW_LIM_NUM 11
`define LPL_HW_LIM_DEN 10
`endif

// file: inc/lpl_pkg.sv
package lpl_pkg;
  // analog samples from the converters
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] power;
    logic [15:0] temp;
    logic [15:0] range;
  } lpl_meas_type;
  // one stored setting group
  typedef struct packed {
    logic [7:0] mode;
    logic [15:0] volt;
    logic [15:0] curr;
  } lpl_group_type;
  // rise/drop timer states, gray along idle-armed-run-hold
  typedef enum logic [1:0] {
    LPL_T_IDLE = 2'b00,
    LPL_T_ARM = 2'b01,
    LPL_T_RUN = 2'b11,
    LPL_T_HOLD = 2'b10
  } lpl_tmr_type;
endpackage : lpl_pkg

// file: rtl/lpl_top.sv
// Function
// - overvoltage: input off, buzzer, two flags latched
// - fault pin high while overvoltage held
// - key or clear command ends protection
// - hardware current cap, flag self clears
// - hardware current cap leaves input state alone
// - software current trip after delay latches off
// - hardware power cap leaves input state alone
// - software power trip after delay latches off
// - overheat above 85 C latches off
// - show matching protection code until cleared
// - no load current below turn-on threshold
// - turn-on latch keeps loading once begun
// - threshold ignored in constant-voltage mode
// - zero threshold replaced by instrument minimum
// - time between voltage marks, hold result
// - after source off, time the drop
// - hundred setting groups, save and recall
// - diode mode draws only above knee voltage
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`include "lpl_consts.svh"
module lpl_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // measurements and events
  input wire lpl_pkg::lpl_meas_type meas_in,
  input wire logic ov_detect_in,
  input wire logic hw_curr_limit_in,
  input wire logic key_press_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // load control and indicators
  output logic input_enable_out,
  output logic draw_enable_out,
  output logic [15:0] curr_cap_out,
  output logic [15:0] power_cap_out,
  output logic buzzer_out,
  output logic fault_pin_out,
  output logic [2:0] prot_code_out,
  output logic irq_out
);
  logic [15:0] ctrl_reg;
  logic [15:0] ocp_lvl_reg, ocp_dly_reg, opp_lvl_reg, opp_dly_reg;
  logic [15:0] von_reg, vmark1_reg, vmark2_reg, knee_reg;
  logic [15:0] ocp_cnt_reg, opp_cnt_reg;
  logic [31:0] timer_reg;
  logic high_voltage_flag, fault_pin_flag, current_trip_flag;
  logic power_trip_flag, heat_trip_flag, protect_summary_flag, sw_oc_reg;
  logic loading_reg, falling_reg;
  logic [`LPL_IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
  logic [6:0] slot_reg;
  lpl_pkg::lpl_group_type work_reg;
  lpl_pkg::lpl_group_type groups_reg [`LPL_SLOTS];
  lpl_pkg::lpl_tmr_type tmr_state_reg;
  logic clear_req, ocp_trip, opp_trip, heat_trip, ov_trip, tmr_done;
  logic wr_ctrl, above_von, draw_next;
  logic [19:0] hw_cap;
  logic ocp_above, opp_above;
  logic [9:0] status_bits;

  assign wr_ctrl = wr_in && (addr_in == `LPL_ADDR_CTRL);
  // clear from any key or from the clear register
  assign clear_req = key_press_in || (wr_in && (addr_in == `LPL_ADDR_CLEAR));
  assign ov_trip = ov_detect_in;
  assign ocp_trip = ctrl_reg[`LPL_CTRL_OCP_EN] && ocp_above &&
                    (ocp_cnt_reg >= ocp_dly_reg);
  assign opp_trip = (opp_lvl_reg != 16'h0000) && opp_above &&
                    (opp_cnt_reg >= opp_dly_reg);
  assign heat_trip = meas_in.temp > `LPL_HEAT_TRIP;
  assign irq_ev = {tmr_done, heat_trip, opp_trip, ocp_trip, ov_trip};
  assign above_von = meas_in.volt > von_reg;
  // one compare each, shared by delay counters and trips
  assign ocp_above = meas_in.curr > ocp_lvl_reg;
  assign opp_above = meas_in.power > opp_lvl_reg;

  // delay counters: run only while above the trip level
  // saturate, so a long overload never wraps back under the delay
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ocp_cnt_reg <= 16'h0000;
      opp_cnt_reg <= 16'h0000;
    end else begin
      if (ocp_above) begin
        if (ocp_cnt_reg != 16'hffff) ocp_cnt_reg <= ocp_cnt_reg + 16'h0001;
      end else begin
        ocp_cnt_reg <= 16'h0000;
      end
      if (opp_above) begin
        if (opp_cnt_reg != 16'hffff) opp_cnt_reg <= opp_cnt_reg + 16'h0001;
      end else begin
        opp_cnt_reg <= 16'h0000;
      end
    end
  end

  // latched trip flags; a trip in the clear cycle wins
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_voltage_flag <= 1'b0;
      fault_pin_flag <= 1'b0;
      sw_oc_reg <= 1'b0;
      power_trip_flag <= 1'b0;
      heat_trip_flag <= 1'b0;
      protect_summary_flag <= 1'b0;
    end else begin
      if (clear_req) begin
        high_voltage_flag <= 1'b0;
        fault_pin_flag <= 1'b0;
        sw_oc_reg <= 1'b0;
        power_trip_flag <= 1'b0;
        heat_trip_flag <= 1'b0;
        protect_summary_flag <= 1'b0;
      end
      if (ov_trip) begin
        high_voltage_flag <= 1'b1;
        fault_pin_flag <= 1'b1;
      end
      if (ocp_trip) begin
        sw_oc_reg <= 1'b1;
        protect_summary_flag <= 1'b1;
      end
      if (opp_trip) begin
        power_trip_flag <= 1'b1;
        protect_summary_flag <= 1'b1;
      end
      if (heat_trip) begin
        heat_trip_flag <= 1'b1;
        protect_summary_flag <= 1'b1;
      end
    end
  end

  // current flag: latched soft trip or live hardware cap
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      current_trip_flag <= 1'b0;
    end else begin
      current_trip_flag <= hw_curr_limit_in || sw_oc_reg || ocp_trip;
    end
  end

  // hardware caps: 110 percent of range, power at set value
  // 20 bits: full-scale range times eleven cannot wrap
  assign hw_cap = ({4'h0, meas_in.range} * 20'(`LPL_HW_LIM_NUM)) / 20'(`LPL_HW_LIM_DEN);
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      curr_cap_out <= 16'h0000;
      power_cap_out <= 16'h0000;
    end else begin
      curr_cap_out <= (hw_cap > 20'h0ffff) ? 16'hffff : hw_cap[15:0];
      power_cap_out <= opp_lvl_reg;
    end
  end

  // input switch: trips force off, caps never touch it
  // a trip beats a ctrl write in the same cycle, so no re-enable into a fault
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `LPL_CTRL_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata_in[15:0];
      // hw_curr_limit_in deliberately absent here
      if (ov_trip || ocp_trip || opp_trip || heat_trip) begin
        ctrl_reg[`LPL_CTRL_INPUT_ON] <= 1'b0;
      end
    end
  end

  // turn-on threshold with optional latch
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loading_reg <= 1'b0;
    end else if (!ctrl_reg[`LPL_CTRL_INPUT_ON]) begin
      loading_reg <= 1'b0;
    end else if (above_von) begin
      loading_reg <= 1'b1;
    end else if (!ctrl_reg[`LPL_CTRL_VON_LATCH]) begin
      loading_reg <= 1'b0;
    end
  end

  // draw gate: threshold skipped in cv mode, knee in diode mode
  always_comb begin
    draw_next = ctrl_reg[`LPL_CTRL_INPUT_ON];
    if (!ctrl_reg[`LPL_CTRL_CV_MODE] && !(loading_reg || above_von)) begin
      draw_next = 1'b0;
    end
    if (ctrl_reg[`LPL_CTRL_DIODE] && !(meas_in.volt > knee_reg)) begin
      draw_next = 1'b0;
    end
  end

  // outputs all registered
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_enable_out <= 1'b0;
      draw_enable_out <= 1'b0;
      buzzer_out <= 1'b0;
      fault_pin_out <= 1'b0;
      prot_code_out <= 3'h0;
      irq_out <= 1'b0;
    end else begin
      input_enable_out <= ctrl_reg[`LPL_CTRL_INPUT_ON];
      draw_enable_out <= draw_next;
      buzzer_out <= high_voltage_flag;
      fault_pin_out <= fault_pin_flag;
      irq_out <= |(irq_stat_reg & irq_mask_reg);
      // code: 1 voltage, 2 current, 3 power, 4 temperature
      if (high_voltage_flag) prot_code_out <= 3'h1;
      else if (sw_oc_reg) prot_code_out <= 3'h2;
      else if (power_trip_flag) prot_code_out <= 3'h3;
      else if (heat_trip_flag) prot_code_out <= 3'h4;
      else prot_code_out <= 3'h0;
    end
  end

  // settings registers; zero threshold takes the minimum
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ocp_lvl_reg <= `LPL_OCP_LVL_RST;
      ocp_dly_reg <= 16'h0000;
      opp_lvl_reg <= 16'h0000;
      opp_dly_reg <= 16'h0000;
      von_reg <= `LPL_VON_MIN;
      vmark1_reg <= 16'h0000;
      vmark2_reg <= 16'h0000;
      knee_reg <= 16'h0000;
    end else if (wr_in) begin
      unique case (addr_in)
        `LPL_ADDR_OCP_LVL: ocp_lvl_reg <= wdata_in[15:0];
        `LPL_ADDR_OCP_DLY: ocp_dly_reg <= wdata_in[15:0];
        `LPL_ADDR_OPP_LVL: opp_lvl_reg <= wdata_in[15:0];
        `LPL_ADDR_OPP_DLY: opp_dly_reg <= wdata_in[15:0];
        `LPL_ADDR_VON: von_reg <= (wdata_in[15:0] < `LPL_VON_MIN) ?
                                  `LPL_VON_MIN : wdata_in[15:0];
        `LPL_ADDR_VMARK1: vmark1_reg <= wdata_in[15:0];
        `LPL_ADDR_VMARK2: vmark2_reg <= wdata_in[15:0];
        `LPL_ADDR_KNEE: knee_reg <= wdata_in[15:0];
        default: ;
      endcase
    end
  end

  // rise/drop timer: arm below start, run between marks, hold
  // timer_reg is kept while disabled so the last result stays readable
  assign tmr_done = (tmr_state_reg == lpl_pkg::LPL_T_RUN) &&
                    (falling_reg ? (meas_in.volt <= vmark1_reg) : (meas_in.volt >= vmark2_reg));
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmr_state_reg <= lpl_pkg::LPL_T_IDLE;
      timer_reg <= 32'h0000_0000;
      falling_reg <= 1'b0;
    end else if (!ctrl_reg[`LPL_CTRL_TIMER_EN]) begin
      tmr_state_reg <= lpl_pkg::LPL_T_IDLE;
      falling_reg <= 1'b0;
    end else begin
      unique case (tmr_state_reg)
        lpl_pkg::LPL_T_IDLE: begin
          // arm only from below the start mark, else a late enable mistimes
          if (meas_in.volt <= vmark1_reg) tmr_state_reg <= lpl_pkg::LPL_T_ARM;
        end
        lpl_pkg::LPL_T_ARM: begin
          // start on crossing the start mark upward
          if (meas_in.volt > vmark1_reg) begin
            timer_reg <= 32'h0000_0000;
            tmr_state_reg <= lpl_pkg::LPL_T_RUN;
          end
        end
        lpl_pkg::LPL_T_RUN: begin
          if (tmr_done) tmr_state_reg <= lpl_pkg::LPL_T_HOLD;
          else timer_reg <= timer_reg + 32'h0000_0001;
        end
        lpl_pkg::LPL_T_HOLD: begin
          // after a rise, a fall below the end mark times the drop
          if (!falling_reg && meas_in.volt < vmark2_reg) begin
            falling_reg <= 1'b1;
            timer_reg <= 32'h0000_0000;
            tmr_state_reg <= lpl_pkg::LPL_T_RUN;
          end
        end
      endcase
    end
  end

  // setting groups: slot write saves or recalls
  // recall only loads the working set; ctrl bits are left as they are
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_reg <= 7'h00;
      work_reg <= '0;
      for (int i = 0; i < `LPL_SLOTS; i++) groups_reg[i] <= '0;
    end else if (wr_in) begin
      unique case (addr_in)
        `LPL_ADDR_SET_MODE: work_reg.mode <= wdata_in[7:0];
        `LPL_ADDR_SET_VOLT: work_reg.volt <= wdata_in[15:0];
        `LPL_ADDR_SET_CURR: work_reg.curr <= wdata_in[15:0];
        `LPL_ADDR_SLOT: begin
          // out-of-range slot numbers are ignored
          if (wdata_in[6:0] <= `LPL_SLOT_MAX) begin
            slot_reg <= wdata_in[6:0];
            if (wdata_in[8]) groups_reg[wdata_in[6:0]] <= work_reg;
            else work_reg <= groups_reg[wdata_in[6:0]];
          end
        end
        default: ;
      endcase
    end
  end

  // interrupts: set wins over write-one-to-clear
  // the mask only gates the pin; status keeps collecting while masked
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_in && addr_in == `LPL_ADDR_IRQ_MASK) irq_mask_reg <= wdata_in[`LPL_IRQ_W-1:0];
      if (wr_in && addr_in == `LPL_ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata_in[`LPL_IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
    end
  end

  // status word, each flag at its fixed position
  always_comb begin
    status_bits = 10'h000;
    status_bits[`LPL_ST_OV] = high_voltage_flag;
    status_bits[`LPL_ST_VF] = fault_pin_flag;
    status_bits[`LPL_ST_OC] = current_trip_flag;
    status_bits[`LPL_ST_OP] = power_trip_flag;
    status_bits[`LPL_ST_OT] = heat_trip_flag;
    status_bits[`LPL_ST_PS] = protect_summary_flag;
    status_bits[`LPL_ST_LOADING] = loading_reg;
    status_bits[`LPL_ST_INPUT] = ctrl_reg[`LPL_CTRL_INPUT_ON];
    status_bits[`LPL_ST_TMR_BUSY] = (tmr_state_reg == lpl_pkg::LPL_T_RUN);
    status_bits[`LPL_ST_FALLING] = falling_reg;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (!rd_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      unique case (addr_in)
        `LPL_ADDR_CTRL: rdata_out <= {16'h0000, ctrl_reg};
        `LPL_ADDR_STATUS: rdata_out <= {22'h000000, status_bits};
        `LPL_ADDR_IRQ_STAT: rdata_out <= {27'h0000000, irq_stat_reg};
        `LPL_ADDR_IRQ_MASK: rdata_out <= {27'h0000000, irq_mask_reg};
        `LPL_ADDR_OCP_LVL: rdata_out <= {16'h0000, ocp_lvl_reg};
        `LPL_ADDR_OCP_DLY: rdata_out <= {16'h0000, ocp_dly_reg};
        `LPL_ADDR_OPP_LVL: rdata_out <= {16'h0000, opp_lvl_reg};
        `LPL_ADDR_OPP_DLY: rdata_out <= {16'h0000, opp_dly_reg};
        `LPL_ADDR_VON: rdata_out <= {16'h0000, von_reg};
        `LPL_ADDR_VMARK1: rdata_out <= {16'h0000, vmark1_reg};
        `LPL_ADDR_VMARK2: rdata_out <= {16'h0000, vmark2_reg};
        `LPL_ADDR_TIMER: rdata_out <= timer_reg;
        `LPL_ADDR_SLOT: rdata_out <= {25'h0000000, slot_reg};
        `LPL_ADDR_SET_MODE: rdata_out <= {24'h000000, work_reg.mode};
        `LPL_ADDR_SET_VOLT: rdata_out <= {16'h0000, work_reg.volt};
        `LPL_ADDR_SET_CURR: rdata_out <= {16'h0000, work_reg.curr};
        `LPL_ADDR_KNEE: rdata_out <= {16'h0000, knee_reg};
        default: rdata_out <= 32'h0000_0000;
      endcase
    end
  end
endmodule : lpl_top

// file: testbench/lpl_top_props.sv
`timescale 1ns/100ps
module lpl_top_props (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // watched inputs
  input wire lpl_pkg::lpl_meas_type meas_in,
  input wire logic ov_detect_in,
  input wire logic key_press_in,
  input wire logic wr_in,
  input wire logic rd_in,
  // watched outputs
  input wire logic [31:0] rdata_out,
  input wire logic input_enable_out,
  input wire logic draw_enable_out,
  input wire logic [15:0] curr_cap_out,
  input wire logic buzzer_out,
  input wire logic fault_pin_out,
  input wire logic [2:0] prot_code_out
);
  logic [19:0] cap_wide;
  logic [15:0] cap_exp;
  // 110 percent of range, wide enough that full scale cannot wrap
  assign cap_wide = (20'(meas_in.range) * 20'd11) / 20'd10;
  assign cap_exp = (cap_wide > 20'h0ffff) ? 16'hffff : cap_wide[15:0];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ov_input_off: assert property (
    ov_detect_in && !wr_in |=> ##1 (!input_enable_out && !draw_enable_out))
    else $error("input left on after overvoltage");
  a_ov_alarm_out: assert property (
    ov_detect_in |=> ##1 (buzzer_out && fault_pin_out))
    else $error("no alarm after overvoltage");
  a_key_clears_pin: assert property (
    key_press_in && !ov_detect_in |=> ##1 !fault_pin_out)
    else $error("fault pin kept after key press");
  a_pin_eq_buzzer: assert property (
    fault_pin_out == buzzer_out)
    else $error("fault pin and buzzer disagree");
  a_cap_scaled: assert property (
    rst_n_in |=> curr_cap_out == $past(cap_exp))
    else $error("current cap not scaled from range");
  a_volt_code_shown: assert property (
    buzzer_out |-> prot_code_out == 3'h1)
    else $error("voltage code not shown");
  a_ov_code_soon: assert property (
    ov_detect_in |-> ##[1:2] prot_code_out == 3'h1)
    else $error("voltage code late");
  a_draw_needs_input: assert property (
    draw_enable_out |-> input_enable_out)
    else $error("drawing with input off");
  a_read_idle_zero: assert property (
    !rd_in |=> rdata_out == 32'h0)
    else $error("read data outside read slot");
endmodule : lpl_top_props
bind lpl_top lpl_top_props i_props (.*);

// file: testbench/lpl_source.sv
`timescale 1ns/100ps
module lpl_source (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // source settings
  input wire logic src_on_in,
  input wire logic [15:0] level_in,
  input wire logic [15:0] slew_in,
  input wire logic [15:0] amps_in,
  input wire logic [15:0] temp_in,
  input wire logic [15:0] range_in,
  // load side
  input wire logic draw_in,
  output lpl_pkg::lpl_meas_type meas_out
);
  logic [15:0] volt_reg;
  logic [15:0] goal;
  logic [15:0] cur;
  // a switched-off source decays to zero; current only while the load draws
  assign goal = src_on_in ? level_in : 16'h0000;
  assign cur = draw_in ? amps_in : 16'h0000;
  // finite slew so rise and drop take measurable time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      volt_reg <= 16'h0000;
    end else if (goal > volt_reg) begin
      volt_reg <= (goal - volt_reg > slew_in) ? volt_reg + slew_in : goal;
    end else begin
      volt_reg <= (volt_reg - goal > slew_in) ? volt_reg - slew_in : goal;
    end
  end
  // converter samples
  always_comb begin
    meas_out.volt = volt_reg;
    meas_out.curr = cur;
    meas_out.power = 16'((32'(volt_reg) * 32'(cur)) >> 8);
    meas_out.temp = temp_in;
    meas_out.range = range_in;
  end
endmodule : lpl_source

// file: testbench/tb.sv
`timescale 1ns/100ps
`include "lpl_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  // design stimulus
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ov_detect_in = 1'b0;
  logic hw_curr_limit_in = 1'b0;
  logic key_press_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  // source settings
  logic src_on = 1'b0;
  logic [15:0] level = 16'h0000;
  logic [15:0] slew = 16'h0010;
  logic [15:0] amps = 16'h0000;
  logic [15:0] temp = 16'h00fa;
  logic [15:0] range = 16'h1000;
  // source samples and design outputs
  lpl_pkg::lpl_meas_type meas_in;
  logic [31:0] rdata_out;
  logic input_enable_out, draw_enable_out, buzzer_out, fault_pin_out, irq_out;
  logic [15:0] curr_cap_out, power_cap_out;
  logic [2:0] prot_code_out;
  // model state
  int n_mismatch = 0;
  int comparisons = 0;
  int seed, t;
  logic [31:0] rv;
  lpl_pkg::lpl_group_type g;
  lpl_pkg::lpl_group_type grp_q[$];
  logic [6:0] slot_q[$];

  always #5 sys_clk_in = ~sys_clk_in;

  lpl_source i_src (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .src_on_in(src_on),
    .level_in(level), .slew_in(slew), .amps_in(amps), .temp_in(temp), .range_in(range),
    .draw_in(draw_enable_out), .meas_out(meas_in));
  lpl_top i_dut (.sys_clk_in, .rst_n_in, .meas_in, .ov_detect_in, .hw_curr_limit_in,
    .key_press_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .input_enable_out,
    .draw_enable_out, .curr_cap_out, .power_cap_out, .buzzer_out, .fault_pin_out,
    .prot_code_out, .irq_out);

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    rv = rdata_out;
    `CHK($sformatf("reg %h", a), e & m, rv & m)
  endtask : rd
  task automatic key;
    @(posedge sys_clk_in);
    key_press_in <= 1'b1;
    @(posedge sys_clk_in);
    key_press_in <= 1'b0;
  endtask : key
  task automatic dv(input logic [15:0] v, input logic e);
    level <= v;
    tick(4);
    `CHK("draw", e, draw_enable_out)
  endtask : dv
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    seed = $urandom(1);
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // reset values, unmapped place, minimum threshold
    rd(`LPL_ADDR_CTRL, 32'h0, '1);
    rd(`LPL_ADDR_OCP_LVL, 32'hffff, '1);
    rd(8'hfc, 32'h0, '1);
    wr(8'hfc, 32'h5);
    wr(`LPL_ADDR_VON, 32'h0);
    rd(`LPL_ADDR_VON, `LPL_VON_MIN, '1);
    // rise and drop timing with a slow source
    wr(`LPL_ADDR_VMARK1, 32'h100);
    wr(`LPL_ADDR_VMARK2, 32'h300);
    wr(`LPL_ADDR_IRQ_MASK, 32'h10);
    wr(`LPL_ADDR_CTRL, 32'h8);
    level <= 16'h0400;
    src_on <= 1'b1;
    tick(80);
    rd(`LPL_ADDR_TIMER, 32'h0, 32'h0);
    t = rv;
    `CHK("rise", 1'b1, t >= 29 && t <= 33)
    rd(`LPL_ADDR_TIMER, t, '1);
    rd(`LPL_ADDR_IRQ_STAT, 32'h10, '1);
    `CHK("irq", 1'b1, irq_out)
    wr(`LPL_ADDR_IRQ_STAT, 32'h10);
    tick(2);
    `CHK("irq", 1'b0, irq_out)
    src_on <= 1'b0;
    tick(80);
    rd(`LPL_ADDR_TIMER, 32'h0, 32'h0);
    `CHK("drop", 1'b1, rv >= 29 && rv <= 33)
    // turn-on gating, voltage mode, latch, diode knee
    slew <= 16'hffff;
    src_on <= 1'b1;
    wr(`LPL_ADDR_VON, 32'h100);
    wr(`LPL_ADDR_CTRL, 32'h1);
    dv(16'h0080, 1'b0);
    wr(`LPL_ADDR_CTRL, 32'h11);
    dv(16'h0080, 1'b1);
    wr(`LPL_ADDR_CTRL, 32'h5);
    dv(16'h0200, 1'b1);
    dv(16'h0080, 1'b1);
    wr(`LPL_ADDR_KNEE, 32'h100);
    wr(`LPL_ADDR_CTRL, 32'h31);
    dv(16'h0080, 1'b0);
    dv(16'h0200, 1'b1);
    // hardware current cap over random ranges, full scale first
    wr(`LPL_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      range <= (i == 0) ? 16'hffff : 16'($urandom);
      tick(3);
      t = int'(range) * 11 / 10;
      `CHK("cap", (t > 65535) ? 16'hffff : 16'(t), curr_cap_out)
    end
    hw_curr_limit_in <= 1'b1;
    rd(`LPL_ADDR_STATUS, 32'h84, 32'h84);
    `CHK("input", 1'b1, input_enable_out)
    hw_curr_limit_in <= 1'b0;
    tick(3);
    rd(`LPL_ADDR_STATUS, 32'h80, 32'h84);
    // power guard, then software power trip cleared by a key
    wr(`LPL_ADDR_OPP_DLY, 32'h3);
    wr(`LPL_ADDR_OPP_LVL, 32'h180);
    tick(2);
    `CHK("pcap", 16'h0180, power_cap_out)
    amps <= 16'h0100;
    tick(2);
    `CHK("input", 1'b1, input_enable_out)
    tick(8);
    rd(`LPL_ADDR_STATUS, 32'h28, 32'hac);
    `CHK("code", 3'h3, prot_code_out)
    key();
    tick(2);
    rd(`LPL_ADDR_STATUS, 32'h0, 32'hbf);
    `CHK("code", 3'h0, prot_code_out)
    wr(`LPL_ADDR_OPP_LVL, 32'h0);
    // software current trip, interrupt masking, clear by command
    wr(`LPL_ADDR_OCP_LVL, 32'h100);
    wr(`LPL_ADDR_OCP_DLY, 32'h5);
    amps <= 16'h0200;
    wr(`LPL_ADDR_CTRL, 32'h3);
    tick(3);
    `CHK("input", 1'b1, input_enable_out)
    tick(10);
    rd(`LPL_ADDR_STATUS, 32'h24, 32'ha4);
    `CHK("code", 3'h2, prot_code_out)
    wr(`LPL_ADDR_IRQ_MASK, 32'h2);
    tick(2);
    `CHK("irq", 1'b1, irq_out)
    wr(`LPL_ADDR_IRQ_MASK, 32'h0);
    tick(2);
    `CHK("irq", 1'b0, irq_out)
    wr(`LPL_ADDR_CLEAR, 32'h1);
    rd(`LPL_ADDR_STATUS, 32'h0, 32'ha4);
    `CHK("input", 1'b0, input_enable_out)
    wr(`LPL_ADDR_IRQ_STAT, 32'h1f);
    rd(`LPL_ADDR_IRQ_STAT, 32'h0, '1);
    // heat trip just above the limit
    wr(`LPL_ADDR_CTRL, 32'h1);
    temp <= `LPL_HEAT_TRIP;
    tick(3);
    `CHK("input", 1'b1, input_enable_out)
    temp <= `LPL_HEAT_TRIP + 16'h0001;
    tick(3);
    rd(`LPL_ADDR_STATUS, 32'h30, 32'hb0);
    `CHK("code", 3'h4, prot_code_out)
    temp <= 16'h0100;
    key();
    rd(`LPL_ADDR_STATUS, 32'h0, 32'h30);
    // overvoltage pulse: alarms held until a key
    wr(`LPL_ADDR_CTRL, 32'h1);
    @(posedge sys_clk_in);
    ov_detect_in <= 1'b1;
    @(posedge sys_clk_in);
    ov_detect_in <= 1'b0;
    tick(6);
    `CHK("alarm", 3'h7, {buzzer_out, fault_pin_out, !input_enable_out})
    `CHK("code", 3'h1, prot_code_out)
    rd(`LPL_ADDR_STATUS, 32'h03, 32'h83);
    key();
    tick(2);
    `CHK("pin", 1'b0, fault_pin_out)
    rd(`LPL_ADDR_STATUS, 32'h0, 32'hbf);
    // setting groups: top slot and a random one, then a refused slot
    for (int i = 0; i < 2; i++) begin
      g = 40'({$urandom, $urandom});
      grp_q.push_back(g);
      slot_q.push_back((i == 0) ? `LPL_SLOT_MAX : 7'($urandom_range(98)));
      wr(`LPL_ADDR_SET_MODE, 32'(g.mode));
      wr(`LPL_ADDR_SET_VOLT, 32'(g.volt));
      wr(`LPL_ADDR_SET_CURR, 32'(g.curr));
      wr(`LPL_ADDR_SLOT, {23'h0, 1'b1, 1'b0, slot_q[i]});
    end
    while (grp_q.size() > 0) begin
      g = grp_q.pop_front();
      t = slot_q.pop_front();
      wr(`LPL_ADDR_SLOT, 32'(t));
      rd(`LPL_ADDR_SET_MODE, 32'(g.mode), '1);
      rd(`LPL_ADDR_SET_VOLT, 32'(g.volt), '1);
      rd(`LPL_ADDR_SET_CURR, 32'(g.curr), '1);
    end
    wr(`LPL_ADDR_SLOT, 32'h64);
    rd(`LPL_ADDR_SLOT, 32'(t), 32'h7f);
    conclude();
  end
endmodule : tb
